// [scb_regs.svh]
// Constants of the clock buffer configuration port: register indices,
// writable masks, reset values and field positions.
// Assumes it is included by its bare name before any module that uses it.
// How it works
// - Target only, one 7-bit address, block transfers
// - Stop after any byte keeps completed bytes
// - Address top bits 1101, bit 2 zero, low two bits from strap
// - Write: address, index N, count X, data
// - Read: index, repeated start, count then data
// - Byte 0 holds six output enables, default on
// - Cleared enable forces output off, pin ignored
// - Byte 1 bits 7:6 report strapped PLL mode
// - Byte 1 bit 5 picks PLL mode source
// - Software PLL mode bits act only when overridden
// - Byte 2 holds per-output edge rate, default fast
// - Byte 3 frequency select enable and choice
// - Byte 3 bit 0 feedback edge rate
// - Byte 5 read-only revision and vendor codes
// - Byte count register is sent first in a read, default 8
// - Byte 6 read-only device type and identifier
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH

// Register indices as sent in the index byte
`define SCB_IDX_OE 8'h00
`define SCB_IDX_PLL 8'h01
`define SCB_IDX_SLEW 8'h02
`define SCB_IDX_FREQ 8'h03
`define SCB_IDX_RSVD 8'h04
`define SCB_IDX_IDENT 8'h05
`define SCB_IDX_DEVID 8'h06
`define SCB_IDX_COUNT 8'h07

// Writable bits of each register; every other bit is fixed
`define SCB_OE_WMASK 8'hdd
`define SCB_PLL_WMASK 8'h3b
`define SCB_SLEW_WMASK 8'hdd
`define SCB_FREQ_WMASK 8'h39
`define SCB_COUNT_WMASK 8'h1f

// Power-up values, reserved bits included
`define SCB_OE_RST 8'hff
`define SCB_PLL_RST 8'h06
`define SCB_SLEW_RST 8'hff
`define SCB_FREQ_RST 8'hc7
`define SCB_COUNT_RST 8'h08
`define SCB_RSVD_VAL 8'hff
`define SCB_UNMAPPED_VAL 8'hff

// Field positions inside byte 1 and byte 3
`define SCB_PLL_OVR_BIT 5
`define SCB_PLL_SW_HI 4
`define SCB_PLL_SW_LO 3
`define SCB_SWING_HI 1
`define SCB_SWING_LO 0
`define SCB_FREQ_EN_BIT 5
`define SCB_FREQ_HI 4
`define SCB_FREQ_LO 3
`define SCB_FB_RATE_BIT 0

// Bit position of each output in bytes 0 and 2, three bits per output, out0 lowest
`define SCB_OUT_POS 18'h3e8d0
`define SCB_NUM_OUT 6

// Fixed upper address bits and frame constants
`define SCB_ADDR_FIXED 4'hd
`define SCB_LAST_BIT 3'h7

`endif

// [scb_pkg.sv]
// Types shared by the configuration port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package scb_pkg;

  // Protocol engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_RACK = 6'h04,
    ST_TX = 6'h08,
    ST_TACK = 6'h10,
    ST_SKIP = 6'h20
  } scb_state_e;

  // Meaning of the byte being received
  typedef enum logic [3:0] {
    K_ADDR = 4'h1,
    K_CMD = 4'h2,
    K_COUNT = 4'h4,
    K_DATA = 4'h8
  } scb_kind_e;

  // Settings handed to the analog clock path
  typedef struct packed {
    logic [5:0] out_drive_en;
    logic [5:0] edge_rate;
    logic [1:0] swing_sel;
    logic [1:0] pll_mode;
    logic freq_sel_en;
    logic [1:0] freq_choice;
    logic feedback_edge_rate;
  } scb_cfg_s;

endpackage

// [scb_link_capture.sv]
// Data capture on the SMBus clock itself.
// Assumes scl_clk is the bus clock pin; it may stand still between frames,
// so nothing here needs an edge outside a frame.
module scb_link_capture (
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic bit_cap
);

  // Data is only guaranteed stable around the rising clock edge, so take it there
  // rather than oversampling late in the high phase; the core reads it much later
  always_ff @(posedge scl_clk) begin
    bit_cap <= sda_in;
  end

endmodule // scb_link_capture

// [scb_cfg_regs.sv]
// SMBus target engine and configuration registers of the clock buffer.
// Assumes the SDA wire is resolved outside from sda_out and sda_oe, and that
// reset is held for at least two core_clk edges after the pins are valid.
`include "scb_regs.svh"

module scb_cfg_regs #(
  parameter logic [3:0] REV_CODE = 4'h5,    // Arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'ha, // Arbitrary value
  parameter logic [1:0] DEV_TYPE = 2'h2,    // Arbitrary value
  parameter logic [5:0] DEV_IDENT = 6'h2a   // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] address_strap_pin,
  input wire logic [1:0] bw_strap_pin,
  input wire logic [5:0] oe_pin_n,
  output scb_pkg::scb_cfg_s cfg
);

  localparam int SYNC_W = 13;

  // Bus data bit as taken on the SMBus clock
  logic link_bit;

  scb_link_capture u_link (
    .scl_clk(scl_clk),
    .sda_in(sda_in),
    .bit_cap(link_bit)
  );

  // Two-flop synchronisers for every pin and for the captured link bit
  logic [SYNC_W-1:0] sync_meta_r;
  logic [SYNC_W-1:0] sync_r;
  wire logic [SYNC_W-1:0] sync_raw = {scl_clk, sda_in, link_bit, address_strap_pin,
                                      bw_strap_pin, oe_pin_n};

  always_ff @(posedge core_clk) begin
    sync_meta_r <= sync_raw;
    sync_r <= sync_meta_r;
  end

  // Synchronised pin levels
  wire logic scl_s = sync_r[12];
  wire logic sda_s = sync_r[11];
  wire logic cap_s = sync_r[10];
  wire logic [1:0] adr_strap_s = sync_r[9:8];
  wire logic [1:0] bw_strap_s = sync_r[7:6];
  wire logic [5:0] oe_pin_n_s = sync_r[5:0];

  // Previous bus levels for edge and condition detection
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Start and stop are SDA edges while SCL stays high
  wire logic scl_fall = scl_d_r & ~scl_s;
  wire logic start_det = scl_d_r & scl_s & sda_d_r & ~sda_s;
  wire logic stop_det = scl_d_r & scl_s & ~sda_d_r & sda_s;

  // Straps are caught once on the first cycle after reset release
  logic strap_done_r;
  logic [1:0] strap_addr_r;
  logic [1:0] strap_bw_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_done_r <= 1'b0;
      strap_addr_r <= 2'h0;
      strap_bw_r <= 2'h0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      strap_addr_r <= adr_strap_s;
      strap_bw_r <= bw_strap_s;
    end
  end

  // Own address: fixed top bits, strap-derived low bits
  wire logic [6:0] my_addr = {`SCB_ADDR_FIXED, 1'b0, strap_addr_r};

  // Protocol engine state
  scb_pkg::scb_state_e st_r;
  scb_pkg::scb_kind_e kind_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] idx_r;
  logic [7:0] wr_left_r;
  logic rw_read_r;
  logic sda_oe_r;
  logic sda_out_r;
  logic start_hold_r;

  // Configuration storage, writable bits only
  logic [7:0] oe_r;
  logic [7:0] pll_r;
  logic [7:0] slew_r;
  logic [7:0] freq_r;
  logic [7:0] count_r;

  // Byte assembly and transfer events
  wire logic [7:0] byte_in = {shift_r[6:0], cap_s};
  wire logic last_bit = (bit_cnt_r == `SCB_LAST_BIT);
  wire logic in_rx = (st_r == scb_pkg::ST_RX);
  wire logic byte_done = in_rx & scl_fall & last_bit;
  wire logic addr_hit = (byte_in[7:1] == my_addr);
  wire logic is_addr = (kind_r == scb_pkg::K_ADDR);
  wire logic is_data = (kind_r == scb_pkg::K_DATA);
  wire logic wr_stb = byte_done & is_data & (wr_left_r != 8'h00);
  wire logic read_go = (st_r == scb_pkg::ST_RACK) & scl_fall & is_addr & rw_read_r;
  wire logic master_ack = ~cap_s;

  // Order of bytes in a write frame: index, count, then data
  wire scb_pkg::scb_kind_e kind_nxt = (kind_r == scb_pkg::K_ADDR) ? scb_pkg::K_CMD :
                                      (kind_r == scb_pkg::K_CMD) ? scb_pkg::K_COUNT :
                                      scb_pkg::K_DATA;

  // Read values; fixed bits come from constants so writes cannot reach them
  wire logic [7:0] rd_oe = oe_r | (`SCB_OE_RST & ~`SCB_OE_WMASK);
  wire logic [7:0] rd_pll = pll_r | (`SCB_PLL_RST & ~`SCB_PLL_WMASK) | {strap_bw_r, 6'h00};
  wire logic [7:0] rd_slew = slew_r | (`SCB_SLEW_RST & ~`SCB_SLEW_WMASK);
  wire logic [7:0] rd_freq = freq_r | (`SCB_FREQ_RST & ~`SCB_FREQ_WMASK);
  wire logic [7:0] rd_ident = {REV_CODE, VENDOR_CODE};
  wire logic [7:0] rd_devid = {DEV_TYPE, DEV_IDENT};
  wire logic [7:0] rd_count = count_r | (`SCB_COUNT_RST & ~`SCB_COUNT_WMASK);

  // Read selection by the running index; past the map reads as all ones
  wire logic [7:0] rd_mux = (idx_r == `SCB_IDX_OE) ? rd_oe :
                            (idx_r == `SCB_IDX_PLL) ? rd_pll :
                            (idx_r == `SCB_IDX_SLEW) ? rd_slew :
                            (idx_r == `SCB_IDX_FREQ) ? rd_freq :
                            (idx_r == `SCB_IDX_RSVD) ? `SCB_RSVD_VAL :
                            (idx_r == `SCB_IDX_IDENT) ? rd_ident :
                            (idx_r == `SCB_IDX_DEVID) ? rd_devid :
                            (idx_r == `SCB_IDX_COUNT) ? rd_count :
                            `SCB_UNMAPPED_VAL;

  // A read frame sends the byte count first, then the bytes from the index on
  wire logic [7:0] tx_load = read_go ? rd_count : rd_mux;

  // Protocol engine. Every SDA change is made just after SCL falls, which keeps
  // the data hold time on the wire; start and stop abort whatever is in flight.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= scb_pkg::ST_IDLE;
      kind_r <= scb_pkg::K_ADDR;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      idx_r <= 8'h00;
      wr_left_r <= 8'h00;
      rw_read_r <= 1'b0;
      sda_oe_r <= 1'b0;
      start_hold_r <= 1'b0;
    end else if (start_det) begin
      st_r <= scb_pkg::ST_RX;
      start_hold_r <= 1'b1;
      kind_r <= scb_pkg::K_ADDR;
      bit_cnt_r <= 3'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= scb_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_fall && start_hold_r) begin  // Fall ending a start carries no bit
      start_hold_r <= 1'b0;
    end else if (scl_fall) begin
      unique case (st_r)
        scb_pkg::ST_IDLE, scb_pkg::ST_SKIP: begin
          sda_oe_r <= 1'b0;
        end
        scb_pkg::ST_RX: begin
          shift_r <= byte_in;
          bit_cnt_r <= bit_cnt_r + 3'h1;
          if (last_bit) begin
            if (is_addr && !addr_hit) begin
              st_r <= scb_pkg::ST_SKIP;
            end else begin
              st_r <= scb_pkg::ST_RACK;
              sda_oe_r <= 1'b1;
            end
            if (is_addr) begin
              rw_read_r <= byte_in[0];
            end
            if (kind_r == scb_pkg::K_CMD) begin
              idx_r <= byte_in;
            end
            if (kind_r == scb_pkg::K_COUNT) begin
              wr_left_r <= byte_in;
            end
            if (wr_stb) begin
              idx_r <= idx_r + 8'h01;
              wr_left_r <= wr_left_r - 8'h01;
            end
          end
        end
        scb_pkg::ST_RACK: begin
          bit_cnt_r <= 3'h0;
          if (read_go) begin
            st_r <= scb_pkg::ST_TX;
            shift_r <= tx_load;
            sda_oe_r <= ~tx_load[7];
          end else begin
            st_r <= scb_pkg::ST_RX;
            kind_r <= kind_nxt;
            sda_oe_r <= 1'b0;
          end
        end
        scb_pkg::ST_TX: begin
          bit_cnt_r <= bit_cnt_r + 3'h1;
          if (last_bit) begin
            st_r <= scb_pkg::ST_TACK;
            sda_oe_r <= 1'b0;
          end else begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_r <= ~shift_r[6];
          end
        end
        scb_pkg::ST_TACK: begin
          bit_cnt_r <= 3'h0;
          if (master_ack) begin
            st_r <= scb_pkg::ST_TX;
            shift_r <= tx_load;
            sda_oe_r <= ~tx_load[7];
            idx_r <= idx_r + 8'h01;
          end else begin
            st_r <= scb_pkg::ST_SKIP;
          end
        end
      endcase
    end
  end

  // Open-drain data pin: the level driven is always low
  always_ff @(posedge core_clk) begin
    sda_out_r <= 1'b0;
  end

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;

  // Per-register write strobes
  wire logic wr_oe = wr_stb & (idx_r == `SCB_IDX_OE);
  wire logic wr_pll = wr_stb & (idx_r == `SCB_IDX_PLL);
  wire logic wr_slew = wr_stb & (idx_r == `SCB_IDX_SLEW);
  wire logic wr_freq = wr_stb & (idx_r == `SCB_IDX_FREQ);
  wire logic wr_count = wr_stb & (idx_r == `SCB_IDX_COUNT);

  // Each byte commits as soon as it is complete, so an early stop keeps it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oe_r <= `SCB_OE_RST & `SCB_OE_WMASK;
      pll_r <= `SCB_PLL_RST & `SCB_PLL_WMASK;
      slew_r <= `SCB_SLEW_RST & `SCB_SLEW_WMASK;
      freq_r <= `SCB_FREQ_RST & `SCB_FREQ_WMASK;
      count_r <= `SCB_COUNT_RST & `SCB_COUNT_WMASK;
    end else begin
      if (wr_oe) begin
        oe_r <= byte_in & `SCB_OE_WMASK;
      end
      if (wr_pll) begin
        pll_r <= byte_in & `SCB_PLL_WMASK;
      end
      if (wr_slew) begin
        slew_r <= byte_in & `SCB_SLEW_WMASK;
      end
      if (wr_freq) begin
        freq_r <= byte_in & `SCB_FREQ_WMASK;
      end
      if (wr_count) begin
        count_r <= byte_in & `SCB_COUNT_WMASK;
      end
    end
  end

  // Gather the scattered per-output bits into output order
  logic [5:0] en_bits;
  logic [5:0] slew_bits;

  for (genvar i = 0; i < `SCB_NUM_OUT; i++) begin : g_out
    localparam logic [2:0] POS = 3'(`SCB_OUT_POS >> (3 * i));
    assign en_bits[i] = oe_r[POS];
    assign slew_bits[i] = slew_r[POS];
  end

  // PLL mode source: strapped value unless software has taken over
  wire logic pll_ovr = pll_r[`SCB_PLL_OVR_BIT];
  wire logic [1:0] pll_sw = pll_r[`SCB_PLL_SW_HI:`SCB_PLL_SW_LO];
  wire logic [1:0] pll_sel = pll_ovr ? pll_sw : strap_bw_r;

  // Settings for the clock path; a cleared enable wins over the pin
  scb_pkg::scb_cfg_s cfg_nxt;

  assign cfg_nxt.out_drive_en = en_bits & ~oe_pin_n_s;
  assign cfg_nxt.edge_rate = slew_bits;
  assign cfg_nxt.swing_sel = pll_r[`SCB_SWING_HI:`SCB_SWING_LO];
  assign cfg_nxt.pll_mode = pll_sel;
  assign cfg_nxt.freq_sel_en = freq_r[`SCB_FREQ_EN_BIT];
  assign cfg_nxt.freq_choice = freq_r[`SCB_FREQ_HI:`SCB_FREQ_LO];
  assign cfg_nxt.feedback_edge_rate = freq_r[`SCB_FB_RATE_BIT];

  // Outputs stay off during reset; they follow the registers one cycle later
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_nxt;
    end
  end

  // The target only ever drives SDA for its own ack and read data
  target_only_a : assert property (
    @(posedge core_clk) disable iff (reset)
    sda_oe_r |-> (st_r == scb_pkg::ST_RACK || st_r == scb_pkg::ST_TX))
    else $error("SDA driven outside an ack or read-data slot");

  // A stop always releases the bus and ends the frame
  stop_ends_a : assert property (
    @(posedge core_clk) disable iff (reset)
    stop_det |=> (st_r == scb_pkg::ST_IDLE) && !sda_oe_r)
    else $error("Stop did not return the engine to idle");

  // An address whose top four bits are not 1101 is never acknowledged
  addr_filter_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (byte_done && is_addr && (byte_in[7:4] != `SCB_ADDR_FIXED))
      |=> (st_r == scb_pkg::ST_SKIP) && !sda_oe_r)
    else $error("Foreign address was acknowledged");

  // A data byte at index 0 lands in byte 0 and the index advances to 1
  write_commit_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (wr_stb && idx_r == `SCB_IDX_OE)
      |=> (oe_r == ($past(byte_in) & `SCB_OE_WMASK)) && (idx_r == `SCB_IDX_PLL))
    else $error("Write byte not stored at its index");

  // A read frame opens with the byte count and its first bit on the wire
  read_count_a : assert property (
    @(posedge core_clk) disable iff (reset)
    read_go |=> (st_r == scb_pkg::ST_TX) && (shift_r == $past(rd_count))
      && (sda_oe_r == !$past(rd_count[7])))
    else $error("Read did not start with the byte count");

  // A cleared enable bit keeps the output off whatever the pin says
  out_force_a : assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 ((cfg.out_drive_en & ~$past(en_bits)) == 6'h00))
    else $error("Disabled output still driven");

  // Software PLL bits matter only under override
  pll_source_a : assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 (cfg.pll_mode == ($past(pll_ovr) ? $past(pll_sw) : $past(strap_bw_r))))
    else $error("PLL mode taken from the wrong source");

  // Byte 4 always reads as all ones
  rsvd_byte_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r == scb_pkg::ST_TACK && scl_fall && master_ack && idx_r == `SCB_IDX_RSVD)
      |=> (shift_r == `SCB_RSVD_VAL))
    else $error("Reserved byte did not read all ones");

  // Reserved bits of byte 0 keep reading their power-up ones after any write
  rsvd_bits_a : assert property (
    @(posedge core_clk) disable iff (reset)
    $past(wr_oe) |-> ((rd_oe & ~`SCB_OE_WMASK) == (`SCB_OE_RST & ~`SCB_OE_WMASK)))
    else $error("Reserved enable bits changed");

  // Power-up values of enables, edge rates and byte count
  reset_values_a : assert property (
    @(posedge core_clk)
    $fell(reset) |-> (rd_oe == `SCB_OE_RST) && (rd_slew == `SCB_SLEW_RST)
      && (rd_count == `SCB_COUNT_RST))
    else $error("Register power-up value wrong");

endmodule // scb_cfg_regs

// [scb_host_model.sv]
// SMBus host model: makes the bus clock and pulls the data wire low when it sends a 0.
// Assumes the bench resolves the open-drain data wire with a pull-up.
// All pin changes land just after a core_clk rising edge.
module scb_host_model (
  input wire logic core_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus: clock stands high and data is released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One bit of 12 cycles. Data moves at cycle 4 of the low phase, after the
  // device's 3-cycle turnaround, so neither side pulls against the other.
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(4);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    r = sda_wire;
    tick(6);
  endtask

  // Start, or repeated start after a released low phase
  task automatic start_cond(input logic rep);
    logic r;
    if (rep) begin
      bit_io(1'b1, r);
    end
    sda_low <= 1'b1;
    tick(6);
  endtask

  // Stop: data low during a clock pulse, then released while the clock is high
  task automatic stop_cond();
    logic r;
    bit_io(1'b0, r);
    sda_low <= 1'b0;
    tick(6);
  endtask

  // Byte out, most significant bit first, then the device's acknowledge slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; the last byte of a read is refused so the device lets go
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // scb_host_model

// [tb.sv]
// Testbench of the clock buffer configuration port: block writes and reads through
// the host model, checked against register values and the cfg outputs.
// Assumes scb_pkg and scb_host_model are compiled before it.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Straps are variables so that a second reset can move them
  logic [1:0] addr_strap = 2'h2;
  logic [1:0] bw_strap = 2'h1;
  wire logic [6:0] dev_addr = {4'hd, 1'b0, addr_strap};
  // Writable bits per index; everything else keeps its fixed value
  localparam logic [7:0] WMASK [0:7] = '{8'hdd, 8'h3b, 8'hdd, 8'h39,
                                         8'h00, 8'h00, 8'h00, 8'h1f};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] oe_pin_n = 6'h00;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  scb_pkg::scb_cfg_s cfg;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] exp_r [0:15];
  logic [7:0] rbuf [0:15];

  always #50 core_clk = ~core_clk;
  // Open-drain wire with pull-up: either party may pull it low
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  scb_host_model host (
    .core_clk(core_clk),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_low(sda_low)
  );

  scb_cfg_regs #(
    .REV_CODE(4'h6),    // Arbitrary value
    .VENDOR_CODE(4'h9), // Arbitrary value
    .DEV_TYPE(2'h1),    // Arbitrary value
    .DEV_IDENT(6'h15)   // Arbitrary value
  ) dut (
    .core_clk(core_clk),
    .reset(reset),
    .scl_clk(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .address_strap_pin(addr_strap),
    .bw_strap_pin(bw_strap),
    .oe_pin_n(oe_pin_n),
    .cfg(cfg)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Send one byte and expect the device to acknowledge it
  task automatic tx(input logic [7:0] d);
    logic ack;
    host.send(d, ack);
    chk(ack, 1'b1);
  endtask

  // Expected register after a stored write: only writable bits move
  task automatic put(input int idx, input logic [7:0] d);
    if (idx < 8) begin
      exp_r[idx] = (exp_r[idx] & ~WMASK[idx]) | (d & WMASK[idx]);
    end
  endtask

  // Block write announcing cnt bytes; the host may stop after fewer
  task automatic wr(input logic [7:0] idx, input logic [7:0] cnt, input int nsend,
                    input logic [63:0] data);
    host.start_cond(1'b0);
    tx({dev_addr, 1'b0});
    tx(idx);
    tx(cnt);
    for (int k = 0; k < nsend; k++) begin
      tx(data[8*k +: 8]);
      // Bytes past the announced count are acked but never stored
      if (k < cnt) begin
        put(idx + k, data[8*k +: 8]);
      end
    end
    host.stop_cond();
  endtask

  // Block read of n bytes after the count byte, then compare all of them
  task automatic rd(input logic [7:0] idx, input int n);
    host.start_cond(1'b0);
    tx({dev_addr, 1'b0});
    tx(idx);
    host.start_cond(1'b1);
    tx({dev_addr, 1'b1});
    for (int k = 0; k <= n; k++) begin
      host.recv(k == n, rbuf[k]);
    end
    host.stop_cond();
    chk(rbuf[0], exp_r[7]);
    for (int k = 0; k < n; k++) begin
      chk(rbuf[k + 1], exp_r[idx + k]);
    end
  endtask

  // Settings expected at the analog side from the register image
  task automatic chk_cfg();
    scb_pkg::scb_cfg_s e;
    e.out_drive_en = {exp_r[0][7:6], exp_r[0][4:2], exp_r[0][0]} & ~oe_pin_n;
    e.edge_rate = {exp_r[2][7:6], exp_r[2][4:2], exp_r[2][0]};
    e.swing_sel = exp_r[1][1:0];
    e.pll_mode = exp_r[1][5] ? exp_r[1][4:3] : bw_strap;
    e.freq_sel_en = exp_r[3][5];
    e.freq_choice = exp_r[3][4:3];
    e.feedback_edge_rate = exp_r[3][0];
    chk(32'(cfg), 32'(e));
  endtask

  // Power-up register image for the straps currently applied
  task automatic init_exp();
    for (int i = 0; i < 16; i++) begin
      exp_r[i] = 8'hff;
    end
    exp_r[1] = {bw_strap, 6'h06};
    exp_r[3] = 8'hc7;
    exp_r[5] = {4'h6, 4'h9};
    exp_r[6] = {2'h1, 6'h15};
    exp_r[7] = 8'h08;
  endtask

  // Main sequence
  initial begin
    logic ack;
    init_exp();
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_cfg();
    rd(8'h00, 8);
    $display("test defaults done");
    wr(8'h00, 8'h07, 7, 64'h0);
    chk_cfg();
    rd(8'h00, 8);
    wr(8'h00, 8'h07, 7, {8{8'hff}});
    chk_cfg();
    rd(8'h00, 8);
    $display("test masks done");
    wr(8'h01, 8'h01, 1, 64'h18);
    chk_cfg();
    wr(8'h02, 8'h03, 1, 64'h41);
    wr(8'h03, 8'h00, 1, 64'h00);
    rd(8'h01, 3);
    oe_pin_n <= 6'h15;
    repeat (5) @(posedge core_clk);
    chk_cfg();
    $display("test overrides done");
    // Every single-bit error in the address must go unanswered
    for (int i = 0; i < 7; i++) begin
      host.start_cond(1'b0);
      host.send({dev_addr ^ (7'h01 << i), 1'b0}, ack);
      chk(ack, 1'b0);
      host.stop_cond();
    end
    $display("test address done");
    wr(8'h07, 8'h01, 1, 64'hff);
    rd(8'h05, 6);
    $display("test count done");
    // Second reset with new straps: the old address goes deaf, defaults return
    addr_strap <= 2'h1;
    bw_strap <= 2'h3;
    reset <= 1'b1;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    init_exp();
    repeat (3) @(posedge core_clk);
    chk_cfg();
    host.start_cond(1'b0);
    host.send({4'hd, 3'h2, 1'b0}, ack);
    chk(ack, 1'b0);
    host.stop_cond();
    rd(8'h00, 8);
    $display("test strap reset done");
    test_done();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (60000) @(posedge core_clk);
    chk(32'h1, 32'h0);
    test_done();
  end
endmodule // tb
